// ===== inc/tcam_pkg.sv
// Shared constants of the ternary rule store and its controller
package tcam_pkg;
  localparam int ENTRY_W  = 52;
  localparam int ACTION_W = 40;
  localparam int FW_W     = 32;
  localparam int DEPTH    = 16;
  localparam int NDEF     = 2;
  localparam int TOT      = DEPTH + NDEF;
  localparam int AW       = 5;
  localparam int NBLK     = 2;
  localparam int BLK_SZ   = 8;
  localparam int OWN_W    = 2;
  localparam int IDX_W    = 4;
  localparam int DSEL_W   = 1;
  localparam int CMD_W    = 3;
  localparam int CNT_W    = 16;

  // Register indices; the byte address on the AXI side is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_RANGE = 4'h1;
  localparam logic [IDX_W-1:0] IDX_BSEL  = 4'h2;
  localparam logic [IDX_W-1:0] IDX_OWNER = 4'h3;
  localparam logic [IDX_W-1:0] IDX_ENT0  = 4'h4;
  localparam logic [IDX_W-1:0] IDX_ENT1  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_MSK0  = 4'h6;
  localparam logic [IDX_W-1:0] IDX_MSK1  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_ACT0  = 4'h8;
  localparam logic [IDX_W-1:0] IDX_ACT1  = 4'h9;
  localparam logic [IDX_W-1:0] IDX_STCNT = 4'ha;
  localparam logic [IDX_W-1:0] IDX_FWCNT = 4'hb;
  localparam logic [IDX_W-1:0] IDX_LAST  = 4'hb;

  // operation_control fields
  localparam int CTRL_TRIG     = 0;
  localparam int CTRL_CLR      = 1;
  localparam int CTRL_EOFF     = 2;
  localparam int CTRL_AOFF     = 3;
  localparam int CTRL_COFF     = 4;
  localparam int CTRL_CMD_LSB  = 5;
  localparam int CTRL_ADDR_LSB = 8;
  // range_config fields
  localparam int RANGE_POS_LSB = 0;
  localparam int RANGE_LEN_LSB = 16;

  localparam logic [CMD_W-1:0] OP_WRITE = 3'h0;
  localparam logic [CMD_W-1:0] OP_READ  = 3'h1;
  localparam logic [CMD_W-1:0] OP_MV_DN = 3'h2;
  localparam logic [CMD_W-1:0] OP_MV_UP = 3'h3;
  localparam logic [CMD_W-1:0] OP_INIT  = 3'h4;

  localparam logic [OWN_W-1:0] OWNER_RST = 2'h0;
  localparam logic [31:0]      REG_RST   = 32'h0;
endpackage : tcam_pkg

// ===== inc/tcam_reg_if.sv
// Register port between the controller and the rule store
`timescale 1ns/1ps
`default_nettype none
interface tcam_reg_if;
  import tcam_pkg::*;
  logic             req;
  logic             we;
  logic [IDX_W-1:0] idx;
  logic [31:0]      wdata;
  logic             ack;
  logic [31:0]      rdata;
  modport dev  (input req, we, idx, wdata, output ack, rdata);
  modport host (output req, we, idx, wdata, input ack, rdata);
endinterface : tcam_reg_if
`default_nettype wire

// ===== src/tcam_rule_lookup_engine.sv
// Ternary rule store with a single-address cache and command engine
`timescale 1ns/1ps
`default_nettype none
// Function
// - highest matching address wins
// - no match applies programmable default rule
// - key builder selects which default rule
// - output action, bump counter, one result
// - data/mask pair decodes per bit
// - egress first lookup: 1/1 is match-any
// - one-bit counter saturates at one
// - one-address cache carries all transfers
// - wide cache fields split over words
// - code 0 writes cache to address
// - code 1 reads address into cache
// - code 4 fills range from cache
// - cache clear disables entry, zeros rest; in ES0_MODE the 1/1 it loads is match-any
// - clear happens before write or fill
// - entry/action/counter transfers separately suppressible
// - software never overwrites active rules
// - software zeroes unused entry/action bits
// - codes 2/3 move block down/up
// - blocks start unallocated, mapped by software
module tcam_rule_lookup_engine import tcam_pkg::*; #(
  parameter bit ES0_MODE = 1'b0
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  tcam_reg_if.dev                  rb,
  input  wire logic                key_valid,
  input  wire logic [ENTRY_W-1:0]  key,
  input  wire logic [DSEL_W-1:0]   default_sel,
  output logic                     res_valid,
  output logic                     res_hit,
  output logic [AW-1:0]            res_addr,
  output logic [ACTION_W-1:0]      res_action,
  output logic                     busy
);
  typedef enum logic {S_IDLE, S_RUN} op_state_e;

  logic [ENTRY_W-1:0]  ent_m [TOT];
  logic [ENTRY_W-1:0]  msk_m [TOT];
  logic [ACTION_W-1:0] act_m [TOT];
  logic                cnt_m [TOT];
  logic [FW_W-1:0]     fw_m  [TOT];

  logic [ENTRY_W-1:0]  c_ent_r;
  logic [ENTRY_W-1:0]  c_msk_r;
  logic [ACTION_W-1:0] c_act_r;
  logic                c_cnt_r;
  logic [FW_W-1:0]     c_fw_r;

  op_state_e           st_r;
  logic                eoff_r, aoff_r, coff_r;
  logic [CMD_W-1:0]    cmd_r;
  logic [AW-1:0]       addr_r;
  logic [AW-1:0]       cur_r;
  logic [CNT_W-1:0]    left_r;
  logic [CNT_W-1:0]    pos_r;
  logic [CNT_W-1:0]    len_r;
  logic [0:0]          bsel_r;
  logic [OWN_W-1:0]    owner_r [NBLK];
  logic                ack_r;
  logic [31:0]         rdata_r;

  // Register access decode
  wire                 wr       = rb.req && rb.we;
  wire                 ctrl_wr  = wr && (rb.idx == IDX_CTRL) && (st_r == S_IDLE);
  wire                 clr_req  = ctrl_wr && rb.wdata[CTRL_CLR];
  wire                 trig_req = ctrl_wr && rb.wdata[CTRL_TRIG];
  wire                 cache_wr = wr && (st_r == S_IDLE);
  wire [CMD_W-1:0]     wcmd     = rb.wdata[CTRL_CMD_LSB +: CMD_W];
  wire [AW-1:0]        waddr    = rb.wdata[CTRL_ADDR_LSB +: AW];

  // Operation step addresses
  wire                 is_move  = (cmd_r == OP_MV_DN) || (cmd_r == OP_MV_UP);
  wire [AW-1:0]        mv_dst   = (cmd_r == OP_MV_UP) ? cur_r + pos_r[AW-1:0]
                                                      : cur_r - pos_r[AW-1:0];
  wire [AW-1:0]        dst      = is_move ? mv_dst : cur_r;
  wire                 last     = (left_r == '0);
  wire                 run_rd   = (st_r == S_RUN) && (cmd_r == OP_READ);
  wire                 run_wr   = (st_r == S_RUN) && (cmd_r != OP_READ);
  wire [ENTRY_W-1:0]   src_ent  = is_move ? ent_m[cur_r] : c_ent_r;
  wire [ENTRY_W-1:0]   src_msk  = is_move ? msk_m[cur_r] : c_msk_r;
  wire [ACTION_W-1:0]  src_act  = is_move ? act_m[cur_r] : c_act_r;
  wire                 src_cnt  = is_move ? cnt_m[cur_r] : c_cnt_r;
  wire [FW_W-1:0]      src_fw   = is_move ? fw_m[cur_r]  : c_fw_r;

  // Match plane
  wire  [DEPTH-1:0]    hit_v;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_match
      wire alloc = (owner_r[gi / BLK_SZ] != OWNER_RST);
      wire live  = ES0_MODE || ~|(ent_m[gi] & msk_m[gi]);
      assign hit_v[gi] = alloc && live && &(msk_m[gi] | ~(ent_m[gi] ^ key));
    end
  endgenerate

  function automatic logic [AW-1:0] top_hit(input logic [DEPTH-1:0] v);
    top_hit = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (v[i]) begin
        top_hit = AW'(i);
      end
    end
  endfunction : top_hit

  wire                 any_hit  = |hit_v;
  wire [AW-1:0]        def_addr = AW'(DEPTH) + AW'(default_sel);
  wire [AW-1:0]        sel_addr = any_hit ? top_hit(hit_v) : def_addr;
  wire                 fw_touch = run_wr && !coff_r && (dst == sel_addr);

  // Rule memory: lookup counters first, operation writes after so they win
  always_ff @(posedge aclk) begin
    if (key_valid && !fw_touch) begin
      cnt_m[sel_addr] <= 1'b1;
      fw_m[sel_addr]  <= fw_m[sel_addr] + FW_W'(1);
    end
    if (run_wr) begin
      if (is_move && pos_r != '0) begin
        if (!eoff_r) begin
          ent_m[cur_r] <= '1;
          msk_m[cur_r] <= '1;
        end
        if (!aoff_r) act_m[cur_r] <= '0;
        if (!coff_r) begin
          cnt_m[cur_r] <= 1'b0;
          fw_m[cur_r]  <= '0;
        end
      end
      if (!eoff_r) begin
        ent_m[dst] <= src_ent;
        msk_m[dst] <= src_msk;
      end
      if (!aoff_r) act_m[dst] <= src_act;
      if (!coff_r) begin
        cnt_m[dst] <= src_cnt;
        fw_m[dst]  <= src_fw;
      end
    end
  end

  // Cache
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_ent_r <= '1;
      c_msk_r <= '1;
      c_act_r <= '0;
      c_cnt_r <= 1'b0;
      c_fw_r  <= '0;
    end else if (clr_req) begin
      c_ent_r <= '1;
      c_msk_r <= '1;
      c_act_r <= '0;
      c_cnt_r <= 1'b0;
      c_fw_r  <= '0;
    end else if (cache_wr) begin
      unique case (rb.idx)
        IDX_ENT0:  c_ent_r[31:0]         <= rb.wdata;
        IDX_ENT1:  c_ent_r[ENTRY_W-1:32] <= rb.wdata[ENTRY_W-33:0];
        IDX_MSK0:  c_msk_r[31:0]         <= rb.wdata;
        IDX_MSK1:  c_msk_r[ENTRY_W-1:32] <= rb.wdata[ENTRY_W-33:0];
        IDX_ACT0:  c_act_r[31:0]         <= rb.wdata;
        IDX_ACT1:  c_act_r[ACTION_W-1:32]<= rb.wdata[ACTION_W-33:0];
        IDX_STCNT: c_cnt_r               <= rb.wdata[0];
        IDX_FWCNT: c_fw_r                <= rb.wdata;
        default: ;
      endcase
    end else if (run_rd || (run_wr && is_move)) begin
      if (!eoff_r) begin
        c_ent_r <= ent_m[cur_r];
        c_msk_r <= msk_m[cur_r];
      end
      if (!aoff_r) c_act_r <= act_m[cur_r];
      if (!coff_r) begin
        c_cnt_r <= cnt_m[cur_r];
        c_fw_r  <= fw_m[cur_r];
      end
    end
  end

  // Command engine and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= S_IDLE;
      eoff_r <= 1'b0;
      aoff_r <= 1'b0;
      coff_r <= 1'b0;
      cmd_r  <= OP_WRITE;
      addr_r <= '0;
      cur_r  <= '0;
      left_r <= '0;
      pos_r  <= '0;
      len_r  <= '0;
      bsel_r <= '0;
      for (int b = 0; b < NBLK; b++) owner_r[b] <= OWNER_RST;
    end else begin
      if (ctrl_wr) begin
        eoff_r <= rb.wdata[CTRL_EOFF];
        aoff_r <= rb.wdata[CTRL_AOFF];
        coff_r <= rb.wdata[CTRL_COFF];
        cmd_r  <= wcmd;
        addr_r <= waddr;
      end
      if (wr && rb.idx == IDX_RANGE) begin
        pos_r <= rb.wdata[RANGE_POS_LSB +: CNT_W];
        len_r <= rb.wdata[RANGE_LEN_LSB +: CNT_W];
      end
      if (wr && rb.idx == IDX_BSEL) bsel_r <= rb.wdata[0];
      if (wr && rb.idx == IDX_OWNER) owner_r[bsel_r] <= rb.wdata[OWN_W-1:0];
      unique case (st_r)
        S_IDLE: if (trig_req) begin
          st_r   <= S_RUN;
          cur_r  <= (wcmd == OP_MV_UP) ? waddr + len_r[AW-1:0] : waddr;
          left_r <= (wcmd == OP_INIT) ? pos_r :
                    (wcmd == OP_MV_UP || wcmd == OP_MV_DN) ? len_r : '0;
        end
        S_RUN: begin
          cur_r  <= (cmd_r == OP_MV_UP) ? cur_r - AW'(1) : cur_r + AW'(1);
          left_r <= left_r - CNT_W'(1);
          if (last) st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Register read port, one cycle after the request
  wire [31:0] ctrl_rd = 32'(addr_r) << CTRL_ADDR_LSB | 32'(cmd_r) << CTRL_CMD_LSB |
                        32'(coff_r) << CTRL_COFF | 32'(aoff_r) << CTRL_AOFF |
                        32'(eoff_r) << CTRL_EOFF | 32'(st_r == S_RUN);
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rb.idx)
      IDX_CTRL:  rd_mux = ctrl_rd;
      IDX_RANGE: rd_mux = {len_r, pos_r};
      IDX_BSEL:  rd_mux = 32'(bsel_r);
      IDX_OWNER: rd_mux = 32'(owner_r[bsel_r]);
      IDX_ENT0:  rd_mux = c_ent_r[31:0];
      IDX_ENT1:  rd_mux = 32'(c_ent_r[ENTRY_W-1:32]);
      IDX_MSK0:  rd_mux = c_msk_r[31:0];
      IDX_MSK1:  rd_mux = 32'(c_msk_r[ENTRY_W-1:32]);
      IDX_ACT0:  rd_mux = c_act_r[31:0];
      IDX_ACT1:  rd_mux = 32'(c_act_r[ACTION_W-1:32]);
      IDX_STCNT: rd_mux = 32'(c_cnt_r);
      IDX_FWCNT: rd_mux = c_fw_r;
      default:   rd_mux = REG_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r      <= 1'b0;
      rdata_r    <= REG_RST;
      res_valid  <= 1'b0;
      res_hit    <= 1'b0;
      res_addr   <= '0;
      res_action <= '0;
    end else begin
      ack_r      <= rb.req;
      rdata_r    <= rb.req ? rd_mux : REG_RST;
      res_valid  <= key_valid;
      res_hit    <= key_valid && any_hit;
      res_addr   <= sel_addr;
      res_action <= act_m[sel_addr];
    end
  end

  assign rb.ack   = ack_r;
  assign rb.rdata = rdata_r;
  assign busy     = (st_r == S_RUN);
endmodule : tcam_rule_lookup_engine
`default_nettype wire

// ===== src/tcam_axil_ctrl.sv
// AXI4-Lite controller that forwards software accesses to the rule store
`timescale 1ns/1ps
`default_nettype none
module tcam_axil_ctrl import tcam_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  tcam_reg_if.host         rb
);
  typedef enum logic [2:0] {H_IDLE, H_WREQ, H_RREQ, H_BRESP, H_RRESP} host_state_e;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  host_state_e      st_r;
  logic             aw_have_r, w_have_r;
  logic [7:0]       aw_r;
  logic [31:0]      w_r;
  logic [3:0]       strb_r;
  logic             req_r, we_r;
  logic [IDX_W-1:0] idx_r;

  // An offset is mapped when aligned and inside the register window
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a[7:2] <= 6'(IDX_LAST));
  endfunction : mapped

  wire aw_hs   = awvalid && awready;
  wire w_hs    = wvalid && wready;
  wire ar_hs   = arvalid && arready;
  // Partial strobes are refused since a merge would need a read of the far register
  wire w_ok    = mapped(aw_r) && (strb_r == 4'hf);
  wire both_in = aw_have_r && w_have_r;
  wire wr_busy = aw_have_r || w_have_r || awvalid || wvalid || awready || wready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= H_IDLE;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= '0;
      w_r       <= '0;
      strb_r    <= '0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      arready   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OK;
      rvalid    <= 1'b0;
      rresp     <= RESP_OK;
      rdata     <= '0;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      idx_r     <= '0;
    end else begin
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      req_r   <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          awready <= awvalid && !awready && !aw_have_r && !arready;
          wready  <= wvalid && !wready && !w_have_r && !arready;
          arready <= arvalid && !arready && !wr_busy;
          if (aw_hs) begin
            aw_r      <= awaddr;
            aw_have_r <= 1'b1;
          end
          if (w_hs) begin
            w_r       <= wdata;
            strb_r    <= wstrb;
            w_have_r  <= 1'b1;
          end
          if (both_in) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            if (w_ok) begin
              req_r <= 1'b1;
              we_r  <= 1'b1;
              idx_r <= aw_r[IDX_W+1:2];
              st_r  <= H_WREQ;
            end else begin
              bvalid <= 1'b1;
              bresp  <= RESP_ERR;
              st_r   <= H_BRESP;
            end
          end else if (ar_hs) begin
            if (mapped(araddr)) begin
              req_r <= 1'b1;
              we_r  <= 1'b0;
              idx_r <= araddr[IDX_W+1:2];
              st_r  <= H_RREQ;
            end else begin
              rvalid <= 1'b1;
              rresp  <= RESP_ERR;
              rdata  <= '0;
              st_r   <= H_RRESP;
            end
          end
        end
        H_WREQ: if (rb.ack) begin
          bvalid <= 1'b1;
          bresp  <= RESP_OK;
          st_r   <= H_BRESP;
        end
        H_RREQ: if (rb.ack) begin
          rvalid <= 1'b1;
          rresp  <= RESP_OK;
          rdata  <= rb.rdata;
          st_r   <= H_RRESP;
        end
        H_BRESP: if (bready) begin
          bvalid <= 1'b0;
          st_r   <= H_IDLE;
        end
        H_RRESP: if (rready) begin
          rvalid <= 1'b0;
          st_r   <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign rb.req   = req_r;
  assign rb.we    = we_r;
  assign rb.idx   = idx_r;
  assign rb.wdata = w_r;
endmodule : tcam_axil_ctrl
`default_nettype wire

// ===== dv/tcam_chk.sv
// Checker for the register link and lookup handshake of the rule store
`timescale 1ns/1ps
`default_nettype none
module tcam_chk import tcam_pkg::*; (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             req,
  input wire logic             we,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [31:0]      wdata,
  input wire logic             ack,
  input wire logic [31:0]      rdata,
  input wire logic             key_valid,
  input wire logic             res_valid,
  input wire logic             busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Only a trigger seen while idle starts a command
  wire             trig_wr = req && we && idx == IDX_CTRL && !busy && wdata[CTRL_TRIG];
  wire [CMD_W-1:0] op      = wdata[CTRL_CMD_LSB +: CMD_W];
  sequence s_single; trig_wr && (op == OP_WRITE || op == OP_READ); endsequence
  sequence s_fill; trig_wr && op == OP_INIT; endsequence
  sequence s_start; ##[1:2] busy; endsequence
  property p_ack_follows; req |=> ack; endproperty
  property p_ack_cause; ack |-> $past(req); endproperty
  property p_ack_pulse; ack |=> !ack; endproperty
  property p_rdata_idle; !ack |-> rdata == 32'h0; endproperty
  property p_res_follows; key_valid |=> res_valid; endproperty
  property p_res_cause; res_valid |-> $past(key_valid); endproperty
  property p_single_done; s_single |-> s_start ##[1:3] !busy; endproperty
  property p_fill_done; s_fill |-> s_start ##[1:40] !busy; endproperty
  property p_busy_cause; $rose(busy) |-> $past(trig_wr) || $past(trig_wr, 2); endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("register answer missing");
  a_ack_cause: assert property (p_ack_cause)
    else $error("register answer without request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("register answer longer than one cycle");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
  a_res_follows: assert property (p_res_follows)
    else $error("lookup result missing");
  a_res_cause: assert property (p_res_cause)
    else $error("lookup result without key");
  a_single_done: assert property (p_single_done)
    else $error("single transfer did not complete in time");
  a_fill_done: assert property (p_fill_done)
    else $error("range fill did not complete in time");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without trigger");
endmodule : tcam_chk
`default_nettype wire

// ===== dv/tcam_rule_lookup_engine_bench.sv
// Bench driving the AXI4-Lite controller and the lookup port of the rule store
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) compare(nm, 64'(ex), 64'(gt))
module tcam_rule_lookup_engine_bench import tcam_pkg::*;;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [7:0]          awaddr = 8'h0;
  logic [7:0]          araddr = 8'h0;
  logic [31:0]         wdata = 32'h0;
  logic [3:0]          wstrb = 4'h0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0, key_valid = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, res_valid, res_hit, busy;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata;
  logic [ENTRY_W-1:0]  key = '0;
  logic [DSEL_W-1:0]   default_sel = '0;
  logic [AW-1:0]       res_addr;
  logic [ACTION_W-1:0] res_action;
  logic [ENTRY_W-1:0]  m_ent [TOT], m_msk [TOT];
  logic [ACTION_W-1:0] m_act [TOT];
  logic                m_stk [TOT];
  logic [31:0]         m_fw [TOT];
  logic [OWN_W-1:0]    m_own [NBLK] = '{default: '0};
  logic [ENTRY_W-1:0]  c_ent = '1, c_msk = '1, base, pat;
  logic [ACTION_W-1:0] c_act = '0;
  logic                c_stk = 1'b0;
  logic [31:0]         c_fw = 32'h0;
  integer              seed = 19846;
  integer              n_mismatch = 0;
  integer              checks_done = 0;

  tcam_reg_if rbi ();
  tcam_axil_ctrl u_tcam_axil_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rb(rbi));
  tcam_rule_lookup_engine #(.ES0_MODE(1'b0)) u_tcam_rule_lookup_engine (.aclk(aclk),
    .aresetn(aresetn), .rb(rbi), .key_valid(key_valid), .key(key),
    .default_sel(default_sel), .res_valid(res_valid), .res_hit(res_hit),
    .res_addr(res_addr), .res_action(res_action), .busy(busy));
  tcam_chk u_tcam_chk (.aclk(aclk), .aresetn(aresetn), .req(rbi.req), .we(rbi.we),
    .idx(rbi.idx), .wdata(rbi.wdata), .ack(rbi.ack), .rdata(rbi.rdata),
    .key_valid(key_valid), .res_valid(res_valid), .busy(busy));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic compare(input string nm, input logic [63:0] ex, input logic [63:0] gt);
    checks_done++;
    if (gt !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt);
    end
  endtask : compare

  task automatic guard(input bit expired);
    if (expired) begin
      n_mismatch++;
      complete_run();
    end
  endtask : guard

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 200);
    bready <= 1'b0;
    guard(t >= 200);
    `CHK("bresp", er, bresp);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 200);
    d = rdata;
    rready <= 1'b0;
    guard(t >= 200);
    `CHK("rresp", er, rresp);
  endtask : axi_rd

  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
    axi_wr({2'b00, i, 2'b00}, d, 4'hf, 2'h0);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] i, output logic [31:0] d);
    axi_rd({2'b00, i, 2'b00}, d, 2'h0);
  endtask : rd

  task automatic clr();
    c_ent = '1;
    c_msk = '1;
    c_act = '0;
    c_stk = 1'b0;
    c_fw  = 32'h0;
  endtask : clr

  task automatic put(input int i, input logic [31:0] f);
    if (!f[CTRL_EOFF]) m_ent[i] = c_ent;
    if (!f[CTRL_EOFF]) m_msk[i] = c_msk;
    if (!f[CTRL_AOFF]) m_act[i] = c_act;
    if (!f[CTRL_COFF]) m_stk[i] = c_stk;
    if (!f[CTRL_COFF]) m_fw[i] = c_fw;
  endtask : put

  task automatic get(input int i);
    c_ent = m_ent[i];
    c_msk = m_msk[i];
    c_act = m_act[i];
    c_stk = m_stk[i];
    c_fw  = m_fw[i];
  endtask : get

  task automatic move(input int s, input int d);
    get(s);
    put(d, 32'h0);
    if (s != d) begin
      m_ent[s] = '1;
      m_msk[s] = '1;
      m_act[s] = '0;
      m_stk[s] = 1'b0;
      m_fw[s]  = 32'h0;
    end
  endtask : move

  // Unused register bits go out as zero
  task automatic ld(input logic [ENTRY_W-1:0] e, input logic [ENTRY_W-1:0] m);
    c_ent = e;
    c_msk = m;
    c_act = ACTION_W'({$random(seed), $random(seed)});
    c_stk = 1'b0;
    c_fw  = 32'h0;
    wr(IDX_ENT0, e[31:0]);
    wr(IDX_ENT1, {12'h0, e[51:32]});
    wr(IDX_MSK0, m[31:0]);
    wr(IDX_MSK1, {12'h0, m[51:32]});
    wr(IDX_ACT0, c_act[31:0]);
    wr(IDX_ACT1, {24'h0, c_act[39:32]});
    wr(IDX_STCNT, 32'h0);
    wr(IDX_FWCNT, 32'h0);
  endtask : ld

  task automatic chk_cache();
    logic [31:0] v;
    logic [31:0] w [8];
    w = '{c_ent[31:0], {12'h0, c_ent[51:32]}, c_msk[31:0], {12'h0, c_msk[51:32]},
          c_act[31:0], {24'h0, c_act[39:32]}, {31'h0, c_stk}, c_fw};
    for (int i = 0; i < 8; i++) begin
      rd(IDX_ENT0 + IDX_W'(i), v);
      `CHK("cache_word", w[i], v);
    end
  endtask : chk_cache

  task automatic cmd(input logic [CMD_W-1:0] op, input int a, input logic [31:0] f,
                     input int pos, input int len, input bit poke);
    logic [31:0] v;
    int t;
    wr(IDX_RANGE, {16'(len), 16'(pos)});
    wr(IDX_CTRL, f | (32'(op) << CTRL_CMD_LSB) | (32'(a) << CTRL_ADDR_LSB) | 32'h1);
    if (poke) wr(IDX_ENT0, 32'h5a5a_a5a5);
    t = 0;
    v = 32'h1;
    while (v[CTRL_TRIG] && t < 60) begin
      rd(IDX_CTRL, v);
      if (poke && t == 0) `CHK("trigger_held", 1'b1, v[CTRL_TRIG]);
      t++;
    end
    guard(t >= 60);
    if (f[CTRL_CLR]) clr();
    case (op)
      OP_WRITE: put(a, f);
      OP_READ:  get(a);
      OP_INIT:  for (int i = a; i <= a + pos; i++) put(i, f);
      OP_MV_UP: for (int i = a + len; i >= a; i--) move(i, i + pos);
      default:  for (int i = a; i <= a + len; i++) move(i, i - pos);
    endcase
  endtask : cmd

  // One idle cycle between keys; each result is checked mid-cycle while it stands
  task automatic look(input logic [ENTRY_W-1:0] k, input logic [DSEL_W-1:0] s);
    int h;
    h = DEPTH + int'(s);
    for (int i = 0; i < DEPTH; i++)
      if (m_own[i / BLK_SZ] != '0 && ((k ^ m_ent[i]) & ~m_msk[i]) == '0 &&
          (m_ent[i] & m_msk[i]) == '0) h = i;
    key_valid   <= 1'b1;
    key         <= k;
    default_sel <= s;
    @(posedge aclk);
    key_valid <= 1'b0;
    @(negedge aclk);
    `CHK("res_valid", 1'b1, res_valid);
    `CHK("res_hit", h < DEPTH, res_hit);
    `CHK("res_addr", h, res_addr);
    `CHK("res_action", m_act[h], res_action);
    m_stk[h] = 1'b1;
    m_fw[h]  = m_fw[h] + 32'h1;
    @(posedge aclk);
  endtask : look

  task automatic burst(input int n);
    logic [ENTRY_W-1:0] k;
    for (int j = 0; j < n; j++) begin
      k = ENTRY_W'({$random(seed), $random(seed)});
      if (j % 4 != 3) k = {base[51:8], k[7:0]};
      if (j % 4 == 0) k[7:0] = pat[7:0];
      look(k, DSEL_W'($random(seed)));
    end
  endtask : burst

  initial begin
    logic [31:0] v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk_cache();
    rd(IDX_OWNER, v);
    `CHK("owner_reset", OWNER_RST, v);
    axi_wr(8'h30, 32'h1, 4'hf, 2'h2);
    axi_rd(8'h3c, v, 2'h2);
    axi_wr(8'h02, 32'h1, 4'hf, 2'h2);
    axi_wr({2'b00, IDX_ENT0, 2'b00}, 32'h1, 4'h3, 2'h2);
    cmd(OP_INIT, 0, 32'h2, TOT - 1, 0, 1'b1);
    chk_cache();
    look('0, 1'b1);
    for (int b = 0; b < NBLK; b++) begin
      wr(IDX_BSEL, 32'(b));
      wr(IDX_OWNER, 32'(b + 1));
      m_own[b] = OWN_W'(b + 1);
    end
    base = ENTRY_W'({$random(seed), $random(seed)}) & ~52'hff;
    pat  = ENTRY_W'($random(seed));
    for (int d = DEPTH; d < TOT; d++) begin
      ld('0, '1);
      cmd(OP_WRITE, d, 32'h0, 0, 0, 1'b0);
    end
    ld(base, 52'hff);
    cmd(OP_WRITE, 3, 32'h0, 0, 0, 1'b0);
    ld({base[51:8], pat[7:0]}, '0);
    cmd(OP_WRITE, 10, 32'h0, 0, 0, 1'b0);
    ld(base | (52'h1 << 40), 52'hff | (52'h1 << 40));
    cmd(OP_WRITE, 12, 32'h0, 0, 0, 1'b0);
    burst(40);
    cmd(OP_READ, 10, 32'h0, 0, 0, 1'b0);
    chk_cache();
    wr(IDX_CTRL, 32'h2);
    clr();
    chk_cache();
    cmd(OP_READ, 10, 32'h0, 0, 0, 1'b0);
    cmd(OP_WRITE, 10, 32'he, 0, 0, 1'b0);
    cmd(OP_READ, 10, 32'h0, 0, 0, 1'b0);
    chk_cache();
    burst(12);
    cmd(OP_MV_UP, 3, 32'h0, 2, 0, 1'b0);
    chk_cache();
    burst(12);
    cmd(OP_MV_DN, 5, 32'h0, 1, 0, 1'b0);
    burst(12);
    cmd(OP_READ, 5, 32'h0, 0, 0, 1'b0);
    chk_cache();
    complete_run();
  end
endmodule : tcam_rule_lookup_engine_bench
`default_nettype wire
